// ### ddr2_pwr_pkg.sv
// Package for the DDR2 power-state and idle-command logic: command pin carrier,
// status carrier, state codes, timing constants and command decode helpers.
// Assumes a link clock of 12 ns and a system clock of 20 MHz.
package ddr2_pwr_pkg;

    // Command pins as sampled at a rising link clock edge, all active low.
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } ddr_cmd_type;

    typedef struct packed {
        logic in_self_refresh;
        logic in_precharge_pd;
        logic in_active_pd;
        logic exiting;
        logic dll_enabled;
        logic dll_locked;
        logic int_clk_enabled;
        logic input_buf_enabled;
        logic contents_lost;
    } power_status_type;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_SREF      = 3'b001,
        ST_SREF_EXIT = 3'b010,
        ST_PPD       = 3'b011,
        ST_APD       = 3'b100,
        ST_PD_EXIT   = 3'b101,
        ST_LOST      = 3'b110
    } pwr_state_type;

    localparam int CNT_W = 8;
    localparam int LINK_PERIOD_PS = 12000;
    localparam int SYS_PERIOD_NS = 50;
    // Link-side minimum times, in link clock cycles unless marked in ns.
    localparam logic [CNT_W-1:0] TCKE_CYC = 8'h03;
    localparam int TXSNR_NS = 205;
    localparam logic [CNT_W-1:0] XSNR_CYC = CNT_W'((TXSNR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
    localparam logic [CNT_W-1:0] TXSRD_CYC = 8'hC8;
    localparam logic [CNT_W-1:0] TXP_CYC = 8'h02;
    localparam logic [CNT_W-1:0] TXARD_CYC = 8'h02;
    localparam logic [CNT_W-1:0] TXARDS_CYC = 8'h08;
    // Refresh interval is a longest time, so the cycle count rounds down.
    localparam int TREFI_NS = 7800;
    localparam int REFI_CYC = TREFI_NS / SYS_PERIOD_NS;
    localparam int PD_REFI_LIMIT = 9;
    localparam int PD_LIMIT_CYC = PD_REFI_LIMIT * REFI_CYC;
    localparam int TMR_W = 12;

    // NOP or Deselect: chip select high, or the three strobes high.
    function automatic logic cmd_is_idle(input ddr_cmd_type c);
        cmd_is_idle = c.cs_n | (c.ras_n & c.cas_n & c.we_n);
    endfunction : cmd_is_idle

    // Refresh pattern; with clock enable low this is self refresh entry.
    function automatic logic cmd_is_refresh(input ddr_cmd_type c);
        cmd_is_refresh = ~c.cs_n & ~c.ras_n & ~c.cas_n & c.we_n;
    endfunction : cmd_is_refresh

endpackage : ddr2_pwr_pkg

// ### level_sync.sv
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit changes slowly compared with the destination clock.
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= level_i;
            sync_ff <= meta_ff;
        end
    end

    assign level_o = sync_ff;
endmodule : level_sync

// ### pulse_sync.sv
// Toggle crossing for single-cycle events between two unrelated clocks.
// A stopped destination clock loses nothing: the toggle waits for its next edge,
// but two events closer together than a few destination cycles cancel each other.
`timescale 1ns/1ps
module pulse_sync (
    input wire logic src_clk_i,
    input wire logic src_rst_i,
    input wire logic src_pulse_i,
    input wire logic dst_clk_i,
    input wire logic dst_rst_i,
    output logic dst_pulse_o
);
    logic tgl_ff;
    logic meta_ff;
    logic sync_ff;
    logic seen_ff;

    always_ff @(posedge src_clk_i or posedge src_rst_i) begin
        if (src_rst_i) begin
            tgl_ff <= 1'b0;
        end else if (src_pulse_i) begin
            tgl_ff <= ~tgl_ff;
        end
    end

    always_ff @(posedge dst_clk_i or posedge dst_rst_i) begin
        if (dst_rst_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            seen_ff <= 1'b0;
        end else begin
            meta_ff <= tgl_ff;
            sync_ff <= meta_ff;
            seen_ff <= sync_ff;
        end
    end

    assign dst_pulse_o = sync_ff ^ seen_ff;
endmodule : pulse_sync

// ### ddr2_power_state_control.sv
// DDR2 power-state control: self refresh, power-down, exit latencies and
// idle commands. Command, clock enable and termination pins are sampled on the
// controller's clock ck_i; the other link inputs come from device logic on ck_i.
// The self refresh timer runs on clk_sys_i, which never stops.
`timescale 1ns/1ps

// Summary of operation
// [RULE1] Low CS RAS CAS CKE, high WE: self refresh
// [RULE2] Termination off before self refresh entry
// [RULE3] In self refresh only clock enable matters
// [RULE4] Self refresh stops DLL, internal clock; timer refreshes
// [RULE5] Refresh within tCKE; stay at least tCKE (first refresh comes on the third clk_sys_i edge after entry)
// [RULE6] Clock may stop after entry, stable before exit
// [RULE7] Only NOP or Deselect until tXSNR passes
// [RULE8] Clock enable high through tXSRD, termination off (odt_i is checked only at self refresh entry)
// [RULE9] Re-entry needs tXSNR and one auto refresh
// [RULE10] Clock enable low with idle command: power-down
// [RULE11] No power-down during bursts or write recovery
// [RULE12] Power-down with locked DLL, else reset after
// [RULE13] All banks closed: precharge, else active power-down
// [RULE14] A12 selects fast or slow active exit
// [RULE15] Power-down disables buffers; precharge also disables DLL
// [RULE16] Power-down lasts at most nine refresh intervals
// [RULE17] Exit on clock enable high; wait exit latency
// [RULE18] Asynchronous clock enable drop loses contents; reinitialize
// [RULE19] Clock change only in precharge power-down
// [RULE20] After clock change, relock DLL with termination off (odt_i is checked only at self refresh entry)
// [RULE21] NOP decode; never ends running operations
// [RULE22] Chip select high is Deselect, strobes ignored
module ddr2_power_state_control
    import ddr2_pwr_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic ck_i,
    input wire ddr_cmd_type cmd_i,
    input wire logic cke_i,
    input wire logic odt_i,
    input wire logic apd_slow_exit_i,
    input wire logic bank_open_i,
    input wire logic burst_busy_i,
    input wire logic reinit_done_i,
    output power_status_type status_o,
    output logic cmd_valid_o,
    output ddr_cmd_type cmd_o,
    output logic illegal_o,
    output logic array_refresh_o,
    output logic pd_overstay_o
);
    logic link_rst_meta_ff;
    logic link_rst_ff;
    pwr_state_type state_ff;
    pwr_state_type nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] relock_ff;
    logic [CNT_W-1:0] nxt_relock;
    logic ref_owed_ff;
    logic nxt_ref_owed;
    logic sr_refreshed_ff;
    logic nxt_sr_refreshed;
    logic cmd_valid_ff;
    logic nxt_cmd_valid;
    ddr_cmd_type cmd_ff;
    logic illegal_ff;
    logic nxt_illegal;
    power_status_type status_ff;
    power_status_type nxt_status;
    logic idle_cmd;
    logic ref_cmd;
    logic sr_tick_link;
    logic [1:0] mode_sys;
    logic sr_prev_ff;
    logic [TMR_W-1:0] refi_tmr_ff;
    logic refresh_ff;
    logic [TMR_W-1:0] pd_tmr_ff;
    logic overstay_ff;
    logic [CNT_W-1:0] xsnr_load;
    logic [CNT_W-1:0] xp_load;
    logic [CNT_W-1:0] xard_load;

    // Reset for the link domain: asserted at once, released on the link clock.
    always_ff @(posedge ck_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link_rst_meta_ff <= 1'b1;
            link_rst_ff <= 1'b1;
        end else begin
            link_rst_meta_ff <= 1'b0;
            link_rst_ff <= link_rst_meta_ff;
        end
    end

    assign idle_cmd = cmd_is_idle(cmd_i); // [RULE21] [RULE22]
    assign ref_cmd = cmd_is_refresh(cmd_i);

    // An exit state lasts one cycle less than its latency, so a command that
    // arrives on the very edge at which the latency has run out is taken.
    assign xsnr_load = XSNR_CYC - 8'h01; // [RULE7]
    assign xp_load = TXP_CYC - 8'h01; // [RULE17]
    assign xard_load = (apd_slow_exit_i ? TXARDS_CYC : TXARD_CYC) - 8'h01; // [RULE14]

    // Internal refresh events from the system clock domain.
    pulse_sync u_refresh_to_link (
        .src_clk_i(clk_sys_i),
        .src_rst_i(sys_rst_i),
        .src_pulse_i(refresh_ff),
        .dst_clk_i(ck_i),
        .dst_rst_i(link_rst_ff),
        .dst_pulse_o(sr_tick_link)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = (cnt_ff == '0) ? '0 : cnt_ff - 1'b1;
        nxt_relock = (relock_ff == '0) ? '0 : relock_ff - 1'b1;
        nxt_ref_owed = ref_owed_ff;
        nxt_sr_refreshed = sr_refreshed_ff | sr_tick_link;
        nxt_cmd_valid = 1'b0;
        nxt_illegal = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (!cke_i) begin
                    if (ref_cmd) begin
                        nxt_state = ST_SREF; // [RULE1]
                        nxt_cnt = '0;
                        nxt_sr_refreshed = 1'b0;
                        // Entry with termination on, a refresh still owed or a
                        // relock running is flagged; the device enters anyway.
                        if (odt_i || ref_owed_ff || relock_ff != '0) begin
                            nxt_illegal = 1'b1; // [RULE2] [RULE9]
                        end
                    end else if (idle_cmd && !burst_busy_i) begin
                        // Row, precharge, mode or refresh timing may still run.
                        nxt_state = bank_open_i ? ST_APD : ST_PPD; // [RULE10] [RULE11] [RULE13]
                        if (relock_ff != '0) begin
                            nxt_illegal = 1'b1; // [RULE8] [RULE12]
                        end
                    end else begin
                        // Any other drop of clock enable is taken as asynchronous.
                        nxt_state = ST_LOST; // [RULE18]
                        nxt_illegal = 1'b1;
                    end
                end else if (!idle_cmd) begin
                    nxt_cmd_valid = 1'b1;
                    if (ref_cmd) begin
                        nxt_ref_owed = 1'b0; // [RULE9]
                    end
                end
            end
            ST_SREF: begin
                // Pins other than clock enable are not looked at here.
                nxt_cnt = (cnt_ff == TCKE_CYC) ? cnt_ff : cnt_ff + 1'b1; // [RULE3]
                if (cke_i) begin
                    if (cnt_ff != TCKE_CYC || !nxt_sr_refreshed) begin
                        nxt_illegal = 1'b1; // [RULE5]
                    end
                    nxt_state = ST_SREF_EXIT;
                    nxt_cnt = xsnr_load; // [RULE7]
                    nxt_relock = TXSRD_CYC; // [RULE8]
                    nxt_ref_owed = 1'b1; // [RULE9]
                end
            end
            ST_SREF_EXIT: begin
                if (!cke_i) begin
                    nxt_state = ST_LOST; // [RULE8]
                    nxt_illegal = 1'b1;
                end else begin
                    if (!idle_cmd) begin
                        nxt_illegal = 1'b1; // [RULE7]
                    end
                    if (cnt_ff <= 8'h01) begin
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_PPD, ST_APD: begin
                if (cke_i) begin
                    nxt_state = ST_PD_EXIT; // [RULE17]
                    if (state_ff == ST_PPD) begin
                        nxt_cnt = xp_load;
                        // The DLL was off and the clock may have changed.
                        nxt_relock = TXSRD_CYC; // [RULE19] [RULE20]
                    end else begin
                        nxt_cnt = xard_load; // [RULE14]
                    end
                end
            end
            ST_PD_EXIT: begin
                if (!cke_i || !idle_cmd) begin
                    nxt_illegal = 1'b1; // [RULE17]
                end
                if (cnt_ff <= 8'h01) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_LOST: begin
                // Only a full initialization brings the device back.
                if (reinit_done_i) begin
                    nxt_state = ST_IDLE; // [RULE18]
                    nxt_cnt = '0;
                    nxt_relock = '0;
                    nxt_ref_owed = 1'b0;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ck_i or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge ck_i or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Relock time of the DLL after a self refresh or precharge power-down exit.
    always_ff @(posedge ck_i or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            relock_ff <= '0;
        end else begin
            relock_ff <= nxt_relock;
        end
    end

    always_ff @(posedge ck_i or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            ref_owed_ff <= 1'b0;
        end else begin
            ref_owed_ff <= nxt_ref_owed;
        end
    end

    always_ff @(posedge ck_i or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            sr_refreshed_ff <= 1'b0;
        end else begin
            sr_refreshed_ff <= nxt_sr_refreshed;
        end
    end

    // A NOP passes nothing downstream, so a running burst is left alone.
    always_ff @(posedge ck_i or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            cmd_valid_ff <= 1'b0;
            cmd_ff <= 4'hF;
        end else begin
            cmd_valid_ff <= nxt_cmd_valid; // [RULE21]
            cmd_ff <= nxt_cmd_valid ? cmd_i : cmd_ff;
        end
    end

    always_ff @(posedge ck_i or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            illegal_ff <= 1'b0;
        end else begin
            illegal_ff <= nxt_illegal;
        end
    end

    always_comb begin
        nxt_status.in_self_refresh = (nxt_state == ST_SREF);
        nxt_status.in_precharge_pd = (nxt_state == ST_PPD);
        nxt_status.in_active_pd = (nxt_state == ST_APD);
        nxt_status.exiting = (nxt_state == ST_SREF_EXIT) || (nxt_state == ST_PD_EXIT);
        nxt_status.dll_enabled = (nxt_state != ST_SREF) && (nxt_state != ST_PPD); // [RULE4] [RULE15]
        nxt_status.dll_locked = nxt_status.dll_enabled && (nxt_relock == '0) && (nxt_state != ST_LOST);
        nxt_status.int_clk_enabled = (nxt_state != ST_SREF); // [RULE4]
        nxt_status.input_buf_enabled = (nxt_state != ST_SREF) && (nxt_state != ST_PPD)
            && (nxt_state != ST_APD); // [RULE15]
        nxt_status.contents_lost = (nxt_state == ST_LOST); // [RULE18]
    end

    always_ff @(posedge ck_i or posedge link_rst_ff) begin
        if (link_rst_ff) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // Self refresh and power-down levels carried to the free-running clock.
    // The link clock may stop one cycle after entry, so the system side times.
    level_sync #(
        .WIDTH(2)
    ) u_mode_to_sys (
        .clk_i(clk_sys_i),
        .rst_i(sys_rst_i),
        .level_i({status_ff.in_self_refresh, status_ff.in_precharge_pd | status_ff.in_active_pd}),
        .level_o(mode_sys)
    );

    // First refresh right after entry, then one per refresh interval.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sr_prev_ff <= 1'b0;
            refi_tmr_ff <= '0;
            refresh_ff <= 1'b0;
        end else begin
            sr_prev_ff <= mode_sys[1];
            refresh_ff <= 1'b0;
            if (mode_sys[1] && !sr_prev_ff) begin
                refresh_ff <= 1'b1; // [RULE4] [RULE5] [RULE6]
                refi_tmr_ff <= TMR_W'(REFI_CYC - 1);
            end else if (mode_sys[1]) begin
                if (refi_tmr_ff == '0) begin
                    refresh_ff <= 1'b1; // [RULE4]
                    refi_tmr_ff <= TMR_W'(REFI_CYC - 1);
                end else begin
                    refi_tmr_ff <= refi_tmr_ff - 1'b1;
                end
            end
        end
    end

    // Power-down residency watch; the flag stays up until power-down ends.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pd_tmr_ff <= '0;
            overstay_ff <= 1'b0;
        end else if (!mode_sys[0]) begin
            pd_tmr_ff <= '0;
            overstay_ff <= 1'b0;
        end else if (pd_tmr_ff == TMR_W'(PD_LIMIT_CYC)) begin
            overstay_ff <= 1'b1; // [RULE16]
        end else begin
            pd_tmr_ff <= pd_tmr_ff + 1'b1;
        end
    end

    assign status_o = status_ff;
    assign cmd_valid_o = cmd_valid_ff;
    assign cmd_o = cmd_ff;
    assign illegal_o = illegal_ff;
    assign array_refresh_o = refresh_ff;
    assign pd_overstay_o = overstay_ff;
endmodule : ddr2_power_state_control

// ### ddr2_pwr_asserts.sv
// Port assertions for the DDR2 power-state block, bound to its instance.
// Assumes the link clock runs whenever a checked transition falls due.
`timescale 1ns/1ps
module ddr2_pwr_asserts
    import ddr2_pwr_pkg::*;
(
    input wire logic sys_rst_i,
    input wire logic ck_i,
    input wire ddr_cmd_type cmd_i,
    input wire logic cke_i,
    input wire logic apd_slow_exit_i,
    input wire logic bank_open_i,
    input wire logic burst_busy_i,
    input wire power_status_type status_o,
    input wire logic cmd_valid_o,
    input wire ddr_cmd_type cmd_o,
    input wire logic illegal_o
);
    logic nop;
    logic ready;
    assign nop = cmd_i.cs_n | (cmd_i.ras_n & cmd_i.cas_n & cmd_i.we_n);
    // Only idle with a locked DLL gives plain entries; idle during a relock also accepts commands, and every other state has side rules.
    assign ready = status_o.dll_locked & ~status_o.exiting & ~status_o.contents_lost & ~status_o.in_self_refresh
        & ~status_o.in_precharge_pd & ~status_o.in_active_pd;
    a_sr_clocks_off: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        status_o.in_self_refresh |-> !(status_o.dll_enabled | status_o.int_clk_enabled)) else $error("clock on in sr");
    a_sr_held: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        status_o.in_self_refresh && !cke_i |=> status_o.in_self_refresh) else $error("sr left early");
    a_pd_enter: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        ready && !cke_i && nop && !burst_busy_i |=> status_o.in_active_pd == $past(bank_open_i)
        && status_o.in_precharge_pd == !$past(bank_open_i)) else $error("wrong pd entry");
    a_nop_quiet: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        nop |=> !cmd_valid_o) else $error("idle command accepted");
    a_cmd_accept: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        ready && cke_i && !nop |=> cmd_valid_o && cmd_o == $past(cmd_i)) else $error("command lost");
    a_exit_refuse: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        status_o.exiting && cke_i && !nop |=> illegal_o && !cmd_valid_o) else $error("command in exit");
    a_ppd_exit: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        status_o.in_precharge_pd && cke_i |=> status_o.exiting [*1] ##1 !status_o.exiting) else $error("bad txp");
    a_apd_fast: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        status_o.in_active_pd && cke_i && !apd_slow_exit_i |=> status_o.exiting [*1] ##1 !status_o.exiting)
        else $error("bad fast exit");
    a_apd_slow: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        status_o.in_active_pd && cke_i && apd_slow_exit_i |=> status_o.exiting [*7] ##1 !status_o.exiting)
        else $error("bad slow exit");
    a_lost_drop: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        ready && !cke_i && burst_busy_i |=> status_o.contents_lost && illegal_o) else $error("drop not flagged");
endmodule : ddr2_pwr_asserts

bind ddr2_power_state_control ddr2_pwr_asserts u_chk (.sys_rst_i(sys_rst_i), .ck_i(ck_i), .cmd_i(cmd_i),
    .cke_i(cke_i), .apd_slow_exit_i(apd_slow_exit_i), .bank_open_i(bank_open_i), .burst_busy_i(burst_busy_i),
    .status_o(status_o), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .illegal_o(illegal_o));

// ### ddr2_ctrl_model.sv
// Controller model: makes the link clock and drives the link pins.
// Assumes the bench calls step from one process at a time.
`timescale 1ns/1ps
module ddr2_ctrl_model
    import ddr2_pwr_pkg::*;
(
    output logic ck_o,
    output ddr_cmd_type cmd_o,
    output logic cke_o,
    output logic odt_o,
    output logic [3:0] side_o
);
    logic run = 1'b1;
    int half = 6;
    initial begin
        ck_o = 1'b0;
        cmd_o = 4'h7;
        cke_o = 1'b1;
        odt_o = 1'b0;
        side_o = 4'h0;
    end
    // The clock halts only when low, so a stop never leaves a short pulse.
    always begin
        #(half);
        if (run | ck_o) begin
            ck_o = ~ck_o;
        end
    end
    task automatic step(input logic k, input ddr_cmd_type c, input logic o, input logic [3:0] s);
        @(negedge ck_o);
        cke_o = k;
        cmd_o = c;
        odt_o = o;
        side_o = s;
        @(posedge ck_o);
        #1;
    endtask : step
endmodule : ddr2_ctrl_model

// ### tb_top.sv
// Self-checking bench for the DDR2 power-state block.
// Assumes the model's link clock is unrelated in phase to the system clock.
`timescale 1ns/1ps
module tb_top;
    import ddr2_pwr_pkg::*;
    localparam ddr_cmd_type NOP = 4'h7;
    localparam ddr_cmd_type DSEL = 4'h8;
    localparam ddr_cmd_type ACT = 4'h3;
    localparam ddr_cmd_type REF = 4'h1;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ck, cke, odt, cmd_valid, illegal, arr_ref, overstay;
    logic ill_seen = 1'b0;
    logic [3:0] side = 4'h0;
    logic [3:0] side_q;
    ddr_cmd_type cmd, cmd_q;
    power_status_type status;
    int fail_count = 0;
    int n_tests = 0;
    int i;
    int s;

    always #25 clk_sys = ~clk_sys;

    ddr2_ctrl_model ctl (.ck_o(ck), .cmd_o(cmd), .cke_o(cke), .odt_o(odt), .side_o(side_q));
    ddr2_power_state_control dut (.clk_sys_i(clk_sys), .sys_rst_i(rst), .ck_i(ck), .cmd_i(cmd), .cke_i(cke),
        .odt_i(odt), .apd_slow_exit_i(side_q[3]), .bank_open_i(side_q[2]), .burst_busy_i(side_q[1]),
        .reinit_done_i(side_q[0]), .status_o(status), .cmd_valid_o(cmd_valid), .cmd_o(cmd_q),
        .illegal_o(illegal), .array_refresh_o(arr_ref), .pd_overstay_o(overstay));

    task automatic stop_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic go(input logic k, input ddr_cmd_type c, input logic o = 1'b0);
        ctl.step(k, c, o, side);
        ill_seen = ill_seen | illegal;
    endtask : go

    // The link reset needs link edges as well, so the clock must run here.
    task automatic reset_dut();
        @(negedge clk_sys);
        rst = 1'b1;
        side = 4'h0;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) go(1'b1, NOP);
        ill_seen = 1'b0;
    endtask : reset_dut

    task automatic exit_wait(input int n);
        for (int k = 0; k <= n; k++) begin
            go(1'b1, NOP);
            chk(status.exiting, k < n - 1);
        end
    endtask : exit_wait

    initial begin
        reset_dut();
        go(1'b1, ACT);
        chk(cmd_valid & (cmd_q === ACT), 1'b1);
        go(1'b1, NOP);
        chk(cmd_valid, 1'b0);
        go(1'b1, DSEL);
        chk(cmd_valid | (cmd_q !== ACT), 1'b0);
        go(1'b0, REF);
        chk(status.in_self_refresh, 1'b1);
        chk(status.dll_enabled | status.int_clk_enabled | status.input_buf_enabled, 1'b0);
        go(1'b0, NOP);
        ctl.run = 1'b0;
        for (i = 0; i < 200 && arr_ref !== 1'b1; i++) begin
            @(negedge clk_sys);
        end
        chk(arr_ref, 1'b1);
        ctl.run = 1'b1;
        for (i = 0; i < 16; i++) begin
            go(1'b0, ddr_cmd_type'(i[3:0]));
        end
        chk(status.in_self_refresh & ~ill_seen, 1'b1);
        exit_wait(int'(XSNR_CYC));
        repeat (200) go(1'b1, NOP);
        ill_seen = 1'b0;
        go(1'b0, REF);
        chk(ill_seen, 1'b1);
        reset_dut();
        go(1'b0, REF, 1'b1);
        chk(illegal, 1'b1);
        reset_dut();
        go(1'b0, REF);
        go(1'b1, NOP);
        chk(ill_seen, 1'b1);
        reset_dut();
        go(1'b0, NOP);
        chk(status.in_precharge_pd, 1'b1);
        chk(status.dll_enabled | status.input_buf_enabled, 1'b0);
        go(1'b1, NOP);
        go(1'b1, ACT);
        chk(illegal & ~cmd_valid, 1'b1);
        go(1'b1, ACT);
        chk(cmd_valid & ~status.dll_locked, 1'b1);
        ill_seen = 1'b0;
        go(1'b0, NOP);
        chk(ill_seen, 1'b1);
        for (s = 0; s < 2; s++) begin
            reset_dut();
            side = {s[0], 3'b100};
            go(1'b0, DSEL);
            chk(status.in_active_pd & ~status.in_precharge_pd & status.dll_enabled, 1'b1);
            exit_wait(s == 1 ? int'(TXARDS_CYC) : int'(TXARD_CYC));
        end
        reset_dut();
        side = 4'h2;
        go(1'b0, NOP);
        chk(status.contents_lost & illegal, 1'b1);
        go(1'b1, ACT);
        chk(cmd_valid, 1'b0);
        side = 4'h1;
        go(1'b1, NOP);
        side = 4'h0;
        go(1'b1, NOP);
        chk(status.contents_lost, 1'b0);
        reset_dut();
        repeat (3) go(1'b0, NOP);
        ctl.half = 9;
        repeat (PD_LIMIT_CYC - 20) @(negedge clk_sys);
        chk(overstay, 1'b0);
        repeat (40) @(negedge clk_sys);
        chk(overstay, 1'b1);
        ctl.half = 6;
        repeat (4) go(1'b0, NOP);
        exit_wait(int'(TXP_CYC));
        chk(status.dll_locked, 1'b0);
        stop_test();
    end

    // The tests need about 76 us; over five times that means a hang.
    initial begin
        #400000;
        fail_count++;
        stop_test();
    end
endmodule : tb_top
